// file: common/srpd_pkg.sv
// Types shared by the control register group
package srpd_pkg;
    typedef struct packed {
        logic wr;
        logic [8:0] addr;
        logic [7:0] data;
    } srpd_wr_t;

    typedef struct packed {
        logic first_loop_powerdown;
        logic oscillator_regulator_powerdown;
        logic oscillator_core_powerdown;
        logic reference_port_powerdown;
        logic sysref_circuit_powerdown;
        logic sysref_delay_powerdown;
        logic pulse_generator_powerdown;
    } srpd_pd_t;

    typedef struct packed {
        logic second_loop_divider_input_sel;
        logic first_loop_delay_input_sel;
        logic [1:0] feedback_source_field;
        logic feedback_path_enable;
    } srpd_fb_t;

    typedef enum logic [1:0] {
        SRPD_IDLE = 2'b00,
        SRPD_HIGH = 2'b01,
        SRPD_LOW = 2'b10
    } srpd_state_t;
endpackage

// file: common/srpd_regs.svh
// Register offsets, field positions, reset values and timing counts
// Contract
// R1: Writing burst length launches that many pulses if pulser selected and powered.
// R2: Burst length is ignored while the source is continuous.
// R3: Burst field 0,1,2,3 gives 1,2,4,8 pulses; resets to 3.
// R4: Feedback bit 4 picks second loop divider input: prescaler or feedback path.
// R5: Feedback bit 3 picks first loop delay input: reference or feedback path.
// R6: Feedback field 2:1 picks output six, output eight, sysref divider, external.
// R7: Host sets feedback enable for zero delay; clear keeps feedback path off.
// R8: Powerdown bits 7..4 stop first loop, regulator, oscillator core, reference port.
// R9: Global sysref powerdown applies each output's own disable mode.
// R10: Sysref circuit powerdown, reset 1, stops sysref outputs and sync.
// R11: Host clears sysref delay powerdown during sync for deterministic phase.
// R12: Bit 0 disables the pulse generator; reset value 1.
// R13: Enable bit 7 for sysref outputs, bits 6..0 for clock outputs 12..0.
// R14: Writing step count starts adjustment on every enabled output.
// R15: Only a serial register write starts dynamic delay adjustment.
// R16: Host sets sync generation method to 3 before adjustment.
// R17: Step count 0 means none; 1 to 15 perform that many steps.
// R18: Source field 0 normal, 1 reclocked, 2 pulser, 3 continuous.
// R19: Method 3 makes the pulser fire on a burst length write from any source except continuous.
// R20: Reserved bits read zero and writes to them do nothing.
`ifndef SRPD_REGS_SVH
`define SRPD_REGS_SVH
// ==========================================================
// Offsets
`define SRPD_OFS_BURST 9'h13e
`define SRPD_OFS_FB 9'h13f
`define SRPD_OFS_PD 9'h140
`define SRPD_OFS_DDEN 9'h141
`define SRPD_OFS_STEP 9'h142
// ==========================================================
// Writable masks
`define SRPD_MASK_BURST 8'h03
`define SRPD_MASK_FB 8'h1f
`define SRPD_MASK_PD 8'hff
`define SRPD_MASK_DDEN 8'hff
`define SRPD_MASK_STEP 8'h0f
// ==========================================================
// Reset values
`define SRPD_RST_BURST 8'h03
`define SRPD_RST_FB 8'h00
`define SRPD_RST_PD 8'h07
`define SRPD_RST_DDEN 8'h00
`define SRPD_RST_STEP 8'h00
// ==========================================================
// Field positions
`define SRPD_FB_N2_BIT 4
`define SRPD_FB_N1_BIT 3
`define SRPD_FB_SRC_LSB 1
`define SRPD_FB_EN_BIT 0
`define SRPD_PD_PLL1_BIT 7
`define SRPD_PD_LDO_BIT 6
`define SRPD_PD_VCO_BIT 5
`define SRPD_PD_REF_BIT 4
`define SRPD_PD_GBL_BIT 3
`define SRPD_PD_SR_BIT 2
`define SRPD_PD_DLY_BIT 1
`define SRPD_PD_PLSR_BIT 0
`define SRPD_DDEN_SR_BIT 7
// ==========================================================
// Encodings and timing
`define SRPD_SRC_PULSER 2'h2
`define SRPD_SRC_CONT 2'h3
`define SRPD_METHOD_WRITE 2'h3
`define SRPD_PULSE_NS 20
`define SRPD_PULSE_CYC ((`SRPD_PULSE_NS + 9) / 10)
`endif

// file: tb/srpd_ctrl_properties.sv
// Assertion checker for the control register group
`include "srpd_regs.svh"
module srpd_ctrl_props
    import srpd_pkg::*;
#(
    parameter int PULSE_CYC = `SRPD_PULSE_CYC,
    parameter int N_SR = 7
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire srpd_wr_t wr_in,
    input wire logic [8:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic [1:0] sysref_source_select,
    input wire logic [1:0] sync_method,
    input wire logic [N_SR-1:0] per_output_disable_mode,
    input wire srpd_fb_t fb_out,
    input wire srpd_pd_t pd_out,
    input wire logic [N_SR-1:0] sysref_output_off,
    input wire logic sysref_pulse,
    input wire logic burst_busy,
    input wire logic [7:0] delay_step,
    input wire logic delay_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================================
    // Decodes
    wire w_any = ce && wr_in.wr;
    wire w_burst = w_any && wr_in.addr == `SRPD_OFS_BURST && !burst_busy;
    wire armed = !pd_out.sysref_circuit_powerdown
        && !pd_out.pulse_generator_powerdown;
    // ==========================================================
    // Properties
    property p_go;
        w_burst && armed && sysref_source_select == 2'h2
            |=> ##1 sysref_pulse && burst_busy;
    endproperty
    a_go: assert property (p_go) else $error("burst did not start");
    property p_cont;
        w_burst && sysref_source_select == 2'h3 |=> ##1 !burst_busy;
    endproperty
    a_cont: assert property (p_cont) else $error("burst in cont");
    property p_plsr;
        w_burst && pd_out.pulse_generator_powerdown |=> ##1 !burst_busy;
    endproperty
    a_plsr: assert property (p_plsr) else $error("burst while off");
    property p_shape;
        $rose(sysref_pulse) |=> sysref_pulse ##1 !sysref_pulse [*2];
    endproperty
    a_shape: assert property (p_shape) else $error("pulse shape");
    property p_quiet;
        !burst_busy |-> !sysref_pulse;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray pulse");
    property p_fb;
        w_any && wr_in.addr == `SRPD_OFS_FB ##1 1'b1
            |=> fb_out == $past(wr_in.data[4:0], 2);
    endproperty
    a_fb: assert property (p_fb) else $error("feedback copy");
    property p_pd;
        w_any && wr_in.addr == `SRPD_OFS_PD ##1 1'b1 |=> pd_out ==
            {$past(wr_in.data[7:4], 2), $past(wr_in.data[2:0], 2)};
    endproperty
    a_pd: assert property (p_pd) else $error("powerdown copy");
    property p_step;
        w_any && wr_in.addr == `SRPD_OFS_STEP && wr_in.data[3:0] != 4'h0
            |=> ##1 delay_active;
    endproperty
    a_step: assert property (p_step) else $error("step not begun");
    property p_act;
        delay_step != 8'h00 |-> delay_active;
    endproperty
    a_act: assert property (p_act) else $error("step while idle");
    property p_unmap;
        rd_addr < `SRPD_OFS_BURST || rd_addr > `SRPD_OFS_STEP
            |=> rd_data == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
endmodule
bind srpd_ctrl srpd_ctrl_props #(
    .PULSE_CYC(PULSE_CYC),
    .N_SR(N_SR)
) u_props (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .wr_in(wr_in),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .sysref_source_select(sysref_source_select),
    .sync_method(sync_method),
    .per_output_disable_mode(per_output_disable_mode),
    .fb_out(fb_out),
    .pd_out(pd_out),
    .sysref_output_off(sysref_output_off),
    .sysref_pulse(sysref_pulse),
    .burst_busy(burst_busy),
    .delay_step(delay_step),
    .delay_active(delay_active)
);

// file: tb/srpd_ctrl_tb.sv
// Self-checking bench for the control register group
module srpd_ctrl_tb
    import srpd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, ce = 1;
    srpd_wr_t wr_in = '0;
    logic [8:0] rd_addr = '0;
    logic [7:0] rd_data, delay_step;
    logic [1:0] sysref_source_select = 2'h2, sync_method = 2'h0;
    logic [6:0] per_output_disable_mode = 7'h55, sysref_output_off;
    srpd_fb_t fb_out;
    srpd_pd_t pd_out;
    logic sysref_pulse, burst_busy, delay_active;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, np, ns, nb;
    srpd_ctrl uut (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .wr_in(wr_in),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .sysref_source_select(sysref_source_select),
        .sync_method(sync_method),
        .per_output_disable_mode(per_output_disable_mode),
        .fb_out(fb_out),
        .pd_out(pd_out),
        .sysref_output_off(sysref_output_off),
        .sysref_pulse(sysref_pulse),
        .burst_busy(burst_busy),
        .delay_step(delay_step),
        .delay_active(delay_active)
    );
    initial begin
        forever #5 clk = ~clk;
    end
    // Hang guard, the whole run needs about 800 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // Bus and compare tasks
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [8:0] a, logic [7:0] d);
        @(posedge clk);
        wr_in <= '{1'b1, a, d};
        @(posedge clk);
        wr_in.wr <= 1'b0;
    endtask
    task automatic rd(logic [8:0] a, logic [7:0] exp);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        #1 chk("rd_data", exp, rd_data);
    endtask
    // Counts pulse rises; a step strobe other than the enables costs 100
    task automatic run(int n);
        logic prev;
        prev = 0;
        np = 0;
        ns = 0;
        nb = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (burst_busy === 1'b1) nb++;
            if (sysref_pulse && !prev) np++;
            prev = sysref_pulse;
            if (delay_step !== 8'h00) ns += (delay_step === 8'ha5) ? 1 : 100;
        end
    endtask
    task automatic burst(logic [1:0] src, logic [1:0] code, int exp);
        @(posedge clk);
        sysref_source_select <= src;
        wr(9'h13e, {6'h3f, code});
        run(60);
        chk("pulses", exp[7:0], np[7:0]);
        chk("busy", 8'(exp * 4), nb[7:0]);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs;
        logic [7:0] m [5] = '{8'h03, 8'h1f, 8'hff, 8'hff, 8'h0f};
        logic [7:0] r [5] = '{8'h03, 8'h00, 8'h07, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) rd(9'(9'h13e + i), r[i]);
        chk("pd_out", 8'h07, {1'b0, pd_out});
        chk("off", 8'h7f, {1'b0, sysref_output_off});
        for (int i = 0; i < 5; i++) begin
            wr(9'(9'h13e + i), 8'hff);
            rd(9'(9'h13e + i), m[i]);
        end
        rd(9'h143, 8'h00);
        chk("fb_out", 8'h1f, {3'h0, fb_out});
        chk("pd_out", 8'h7f, {1'b0, pd_out});
        wr(9'h13f, 8'h0a);
        rd(9'h141, 8'hff);
        chk("fb_out", 8'h0a, {3'h0, fb_out});
    endtask
    task automatic t_off;
        wr(9'h140, 8'h08);
        rd(9'h140, 8'h08);
        chk("off", 8'h55, {1'b0, sysref_output_off});
        wr(9'h140, 8'h04);
        rd(9'h140, 8'h04);
        chk("off", 8'h7f, {1'b0, sysref_output_off});
    endtask
    task automatic t_burst;
        wr(9'h140, 8'h00);
        for (int c = 0; c < 4; c++) burst(2'h2, c[1:0], 1 << c);
        burst(2'h3, 2'h3, 0);
        burst(2'h0, 2'h3, 0);
        burst(2'h1, 2'h3, 0);
        @(posedge clk);
        sync_method <= 2'h3;
        burst(2'h0, 2'h1, 2);
        wr(9'h140, 8'h01);
        burst(2'h2, 2'h3, 0);
        wr(9'h140, 8'h04);
        burst(2'h2, 2'h3, 0);
    endtask
    task automatic t_step;
        int s [3] = '{0, 1, 15};
        @(posedge clk);
        sync_method <= 2'h3;
        wr(9'h141, 8'ha5);
        for (int i = 0; i < 3; i++) begin
            wr(9'h142, s[i][7:0]);
            run(25);
            chk("steps", s[i][7:0], ns[7:0]);
        end
        @(posedge clk);
        sync_method <= 2'h1;
        run(25);
        chk("steps", 8'h00, ns[7:0]);
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_off();
        t_burst();
        t_step();
        tally_and_finish();
    end
endmodule

// file: verilog/srpd_ctrl.sv
// Sysref, feedback and powerdown control register group
`include "srpd_regs.svh"
module srpd_ctrl
    import srpd_pkg::*;
#(
    parameter int PULSE_CYC = `SRPD_PULSE_CYC,
    parameter int N_SR = 7
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire srpd_wr_t wr_in,
    input wire logic [8:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic [1:0] sysref_source_select,
    input wire logic [1:0] sync_method,
    input wire logic [N_SR-1:0] per_output_disable_mode,
    output srpd_fb_t fb_out,
    output srpd_pd_t pd_out,
    output logic [N_SR-1:0] sysref_output_off,
    output logic sysref_pulse,
    output logic burst_busy,
    output logic [7:0] delay_step,
    output logic delay_active
);
    // ==========================================================
    // Registers
    logic [7:0] burst_reg;
    logic [7:0] fb_reg;
    logic [7:0] pd_reg;
    logic [7:0] dden_reg;
    logic [7:0] step_reg;

    function automatic logic hit(input srpd_wr_t w, input logic [8:0] a);
        return w.wr && (w.addr == a);
    endfunction

    wire wr_burst = hit(wr_in, `SRPD_OFS_BURST);
    wire wr_fb = hit(wr_in, `SRPD_OFS_FB);
    wire wr_pd = hit(wr_in, `SRPD_OFS_PD);
    wire wr_dden = hit(wr_in, `SRPD_OFS_DDEN);
    wire wr_step = hit(wr_in, `SRPD_OFS_STEP); // [R15]

    always_ff @(posedge clk) begin
        if (reset) begin
            burst_reg <= `SRPD_RST_BURST; // [R3]
            fb_reg <= `SRPD_RST_FB;
            pd_reg <= `SRPD_RST_PD; // [R10] [R12]
            dden_reg <= `SRPD_RST_DDEN;
            step_reg <= `SRPD_RST_STEP;
        end else if (ce) begin
            // Reserved bits masked off so they read zero [R20]
            if (wr_burst) burst_reg <= wr_in.data & `SRPD_MASK_BURST;
            if (wr_fb) fb_reg <= wr_in.data & `SRPD_MASK_FB;
            if (wr_pd) pd_reg <= wr_in.data & `SRPD_MASK_PD;
            if (wr_dden) dden_reg <= wr_in.data & `SRPD_MASK_DDEN;
            if (wr_step) step_reg <= wr_in.data & `SRPD_MASK_STEP;
        end
    end

    // ==========================================================
    // Read mux, unmapped reads zero
    wire [7:0] rd_mux =
        (rd_addr == `SRPD_OFS_BURST) ? burst_reg :
        (rd_addr == `SRPD_OFS_FB) ? fb_reg :
        (rd_addr == `SRPD_OFS_PD) ? pd_reg :
        (rd_addr == `SRPD_OFS_DDEN) ? dden_reg :
        (rd_addr == `SRPD_OFS_STEP) ? step_reg : 8'h00;

    // ==========================================================
    // Burst launch
    wire sr_up = !pd_reg[`SRPD_PD_SR_BIT] && !pd_reg[`SRPD_PD_PLSR_BIT];
    wire src_pulser = (sysref_source_select == `SRPD_SRC_PULSER); // [R18]
    wire src_cont = (sysref_source_select == `SRPD_SRC_CONT); // [R2]
    wire method_wr = (sync_method == `SRPD_METHOD_WRITE); // [R19]
    // Write to burst register fires once; busy burst ignores re-launch
    wire burst_go = wr_burst && sr_up && !src_cont
        && (src_pulser || method_wr); // [R1] [R12] [R2]
    wire raw_pulse;
    wire pulser_busy;

    srpd_pulser #(
        .PULSE_CYC(PULSE_CYC)
    ) u_pulser (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .start(burst_go),
        .burst_code(wr_in.data[1:0]),
        .pulse(raw_pulse),
        .busy(pulser_busy)
    );

    // ==========================================================
    // Dynamic delay
    wire step_raw;
    wire step_busy;
    srpd_stepper u_step (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .start(wr_step), // [R14] [R15]
        .steps(wr_in.data[3:0]),
        .step(step_raw),
        .active(step_busy)
    );

    // ==========================================================
    // Decoded controls
    wire [N_SR-1:0] gbl_off = pd_reg[`SRPD_PD_GBL_BIT]
        ? per_output_disable_mode : '0; // [R9]
    wire [N_SR-1:0] off_next = pd_reg[`SRPD_PD_SR_BIT]
        ? '1 : gbl_off; // [R10]
    wire srpd_fb_t fb_next = '{
        second_loop_divider_input_sel: fb_reg[`SRPD_FB_N2_BIT], // [R4]
        first_loop_delay_input_sel: fb_reg[`SRPD_FB_N1_BIT], // [R5]
        feedback_source_field: fb_reg[`SRPD_FB_SRC_LSB +: 2], // [R6]
        feedback_path_enable: fb_reg[`SRPD_FB_EN_BIT] // [R7]
    };
    wire srpd_pd_t pd_next = '{
        first_loop_powerdown: pd_reg[`SRPD_PD_PLL1_BIT], // [R8]
        oscillator_regulator_powerdown: pd_reg[`SRPD_PD_LDO_BIT],
        oscillator_core_powerdown: pd_reg[`SRPD_PD_VCO_BIT],
        reference_port_powerdown: pd_reg[`SRPD_PD_REF_BIT],
        sysref_circuit_powerdown: pd_reg[`SRPD_PD_SR_BIT],
        sysref_delay_powerdown: pd_reg[`SRPD_PD_DLY_BIT], // [R11]
        pulse_generator_powerdown: pd_reg[`SRPD_PD_PLSR_BIT]
    };
    // Enabled outputs only receive step strobes [R13]
    wire [7:0] step_next = step_raw ? dden_reg : 8'h00;

    // ==========================================================
    // Output flops
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= 8'h00;
            fb_out <= '0;
            pd_out <= '0;
            sysref_output_off <= '1;
            sysref_pulse <= 1'b0;
            burst_busy <= 1'b0;
            delay_step <= 8'h00;
            delay_active <= 1'b0;
        end else if (ce) begin
            rd_data <= rd_mux;
            fb_out <= fb_next;
            pd_out <= pd_next;
            sysref_output_off <= off_next;
            // Powerdown mid-burst silences the pulse at once
            sysref_pulse <= raw_pulse && sr_up;
            burst_busy <= pulser_busy;
            delay_step <= step_next;
            delay_active <= step_busy;
        end
    end
endmodule

// file: verilog/srpd_pulser.sv
// Sysref burst generator
`include "srpd_regs.svh"
module srpd_pulser
    import srpd_pkg::*;
#(
    parameter int PULSE_CYC = `SRPD_PULSE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic start,
    input wire logic [1:0] burst_code,
    output logic pulse,
    output logic busy
);
    // ==========================================================
    // Burst sequencer
    srpd_state_t state_reg;
    srpd_state_t state_next;
    logic [3:0] left_reg;
    logic [7:0] cyc_reg;
    wire cyc_done = (cyc_reg == 8'(PULSE_CYC - 1));
    wire [3:0] burst_len = 4'h1 << burst_code; // [R3]

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SRPD_IDLE: if (start) state_next = SRPD_HIGH;
            SRPD_HIGH: if (cyc_done) state_next = SRPD_LOW;
            SRPD_LOW: begin
                if (cyc_done) begin
                    state_next = (left_reg == 4'h1) ? SRPD_IDLE : SRPD_HIGH;
                end
            end
            default: state_next = SRPD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= SRPD_IDLE;
            left_reg <= 4'h0;
            cyc_reg <= 8'h00;
            pulse <= 1'b0;
            busy <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            cyc_reg <= (state_reg == SRPD_IDLE || cyc_done) ? 8'h00
                : cyc_reg + 8'h01;
            if (state_reg == SRPD_IDLE && start) left_reg <= burst_len; // [R1]
            else if (state_reg == SRPD_LOW && cyc_done)
                left_reg <= left_reg - 4'h1;
            pulse <= (state_next == SRPD_HIGH);
            busy <= (state_next != SRPD_IDLE);
        end
    end
endmodule

// file: verilog/srpd_stepper.sv
// Dynamic delay step sequencer, one step strobe per cycle
module srpd_stepper (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic start,
    input wire logic [3:0] steps,
    output logic step,
    output logic active
);
    // ==========================================================
    // Step counter
    logic [3:0] left_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            left_reg <= 4'h0;
            step <= 1'b0;
            active <= 1'b0;
        end else if (ce) begin
            if (start) begin
                left_reg <= steps; // [R17]
                step <= 1'b0;
                active <= (steps != 4'h0);
            end else if (left_reg != 4'h0) begin
                left_reg <= left_reg - 4'h1;
                step <= 1'b1;
                active <= 1'b1;
            end else begin
                step <= 1'b0;
                active <= 1'b0;
            end
        end
    end
endmodule
